//--- logic/ttps_regs.svh
// Register offsets, field positions, reset values and timing figures.
`ifndef TTPS_REGS_SVH
`define TTPS_REGS_SVH
// ============================================================
// Register byte offsets
`define TTPS_OFS_CMD      8'h00
`define TTPS_OFS_FORMAT   8'h04
`define TTPS_OFS_CHSEL    8'h08
`define TTPS_OFS_TEXT     8'h0C
`define TTPS_OFS_REC0     8'h10
`define TTPS_OFS_REC1     8'h14
`define TTPS_OFS_REC2     8'h18
`define TTPS_OFS_REC3     8'h1C
`define TTPS_OFS_PERIOD   8'h20
`define TTPS_OFS_CONT     8'h24
`define TTPS_OFS_SDATE    8'h28
`define TTPS_OFS_STIME    8'h2C
`define TTPS_OFS_STATUS   8'h30
`define TTPS_OFS_IRQ_ST   8'h34
`define TTPS_OFS_IRQ_CLR  8'h38
`define TTPS_OFS_IRQ_EN   8'h3C
`define TTPS_OFS_SERCFG   8'h40
// ============================================================
// Field positions
`define TTPS_CMD_CLEAR    0
`define TTPS_CMD_PRESET   1
`define TTPS_REC_VALID    31
`define TTPS_NUM_CH       3
`define TTPS_NUM_IRQ      5
`define TTPS_IRQ_PULSE    3
`define TTPS_IRQ_POWER    4
`define TTPS_TXT_LEN      6'h23
`define TTPS_CHAR_COMMA   8'h2C
`define TTPS_CHAR_ZERO    8'h30
// ============================================================
// Reset and factory default values
`define TTPS_DEF_PERIOD   16'h0001
`define TTPS_DEF_CHSEL    2'h1
`define TTPS_DEF_SDATE    32'h0000_0000
`define TTPS_DEF_STIME    24'h00_0000
// ============================================================
// Timing figures
`define TTPS_CLK_MHZ      40
`define TTPS_CLK_KHZ      40000
`define TTPS_PULSE_US     20
`define TTPS_SELFTEST_MS  15000
`define TTPS_BAUD         9600
`endif

//--- logic/ttps_pkg.sv
// Types shared by the time tag and pulse scheduler modules.
package ttps_pkg;
  // ============================================================
  // Captured record: yyyy mm dd hh mm ssssssss xxxxxxxxx as BCD.
  typedef logic [115:0] ttps_rec_t;
  // ============================================================
  // Pulse scheduler states.
  typedef enum logic [3:0] {
    PS_IDLE  = 4'b0001,
    PS_WAIT  = 4'b0010,
    PS_RUN   = 4'b0100,
    PS_PULSE = 4'b1000
  } ttps_pst_t;
endpackage

//--- logic/ttps_fmt_if.sv
// Carrier between the capture core and the text formatter.
interface ttps_fmt_if;
  ttps_pkg::ttps_rec_t digits;
  logic [5:0]          idx;
  logic [7:0]          chr;
  modport src (output digits, output idx, input chr);
  modport fmt (input digits, input idx, output chr);
endinterface

//--- logic/ttps_fmt.sv
// Turns a BCD time tag record into one character of its text form.
`include "ttps_regs.svh"
module ttps_fmt (
  // Record and character index in, character out
  ttps_fmt_if.fmt fmt_b
);
  // ============================================================
  // Digit number for a character slot; commas answer with 5'h1F.
  function automatic logic [4:0] slot_digit(input logic [5:0] i);
    logic [4:0] d;
    d = 5'h1F;
    if (i < 6'h04) d = i[4:0];
    else if (i > 6'h04 && i < 6'h07) d = 5'(i - 6'h01);
    else if (i > 6'h07 && i < 6'h0A) d = 5'(i - 6'h02);
    else if (i > 6'h0A && i < 6'h0D) d = 5'(i - 6'h03);
    else if (i > 6'h0D && i < 6'h10) d = 5'(i - 6'h04);
    else if (i > 6'h10 && i < 6'h19) d = 5'(i - 6'h05);
    else if (i > 6'h19 && i < `TTPS_TXT_LEN) d = 5'(i - 6'h06);
    return d;
  endfunction

  logic [4:0] dig;
  logic [3:0] nib;

  // ============================================================
  // comma separated field order
  always_comb begin
    dig = slot_digit(fmt_b.idx);
    nib = 4'h0;
    if (dig == 5'h1F) begin
      fmt_b.chr = `TTPS_CHAR_COMMA;
    end else begin
      // Only a digit slot indexes the record, so the slice stays in range.
      nib = fmt_b.digits[7'(115 - 4 * int'(dig)) -: 4];
      fmt_b.chr = `TTPS_CHAR_ZERO + {4'h0, nib};
    end
  end
endmodule

//--- logic/ttps_top.sv
// Time tag capture and scheduled pulse train with a register port.
// ============================================================
// How it works
// - Clear command empties every capture record except one whose edge lands in that cycle.
// - Text format reports records as characters.
// - Three event inputs each store timestamps.
// - Host reads the record of selected channel.
// - Record fields: year,month,day,hour,min,sec,sub.
// - Period in seconds; one gives 1 PPS.
// - Continuous mode repeats pulses at period.
// - Start programmed as date and 24-hour time.
// - Start already past: pulses begin at the next tick.
// - Future start: output idle until reached.
// - Self-test shows power, no alarm in time.
// - No antenna at power-up: extended search.
// - Preset restores factory parameter defaults.
// - Host serial link 9600 baud, 8N1; only the 9600 baud divisor is implemented, readable at SERCFG.
`include "ttps_regs.svh"
module ttps_top #(
  parameter int unsigned SELFTEST_CYC = `TTPS_SELFTEST_MS * `TTPS_CLK_KHZ,
  parameter int unsigned PULSE_CYC    = `TTPS_PULSE_US * `TTPS_CLK_MHZ
) (
  // Clock, reset, enable
  input  wire logic        clock_i,
  input  wire logic        resetn_i,
  input  wire logic        ce_i,
  // Register port
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_we_i,
  input  wire logic        reg_re_i,
  output logic      [31:0] reg_rdata_o,
  // Time from the precise clock subsystem
  input  wire logic [115:0] tod_bcd_i,
  input  wire logic        pps_tick_i,
  // Pins
  input  wire logic [2:0]  event_i,
  input  wire logic        antenna_ok_i,
  input  wire logic        selftest_ok_i,
  output logic             pulse_o,
  output logic             power_led_o,
  output logic             alarm_o,
  output logic             ext_search_o,
  output logic             irq_o
);
  localparam int WW = $clog2(PULSE_CYC + 1);
  localparam int PW = $clog2(SELFTEST_CYC + 1);
  localparam logic [31:0] BAUD_DIV = 32'(`TTPS_CLK_KHZ * 1000 / `TTPS_BAUD);

  if (PULSE_CYC < 1 || SELFTEST_CYC < 8) begin : g_chk
    $error("ttps_top: pulse or self-test count too small");
  end

  // ============================================================
  // Pin synchronisers
  logic [2:0] ev_meta_q, ev_sync_q, ev_last_q;
  logic [1:0] pin_meta_q, pin_sync_q;
  logic [2:0] ev_edge;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ev_meta_q  <= 3'h0;
      ev_sync_q  <= 3'h0;
      ev_last_q  <= 3'h0;
      pin_meta_q <= 2'h0;
      pin_sync_q <= 2'h0;
    end else if (ce_i) begin
      ev_meta_q  <= event_i;
      ev_sync_q  <= ev_meta_q;
      ev_last_q  <= ev_sync_q;
      pin_meta_q <= {selftest_ok_i, antenna_ok_i};
      pin_sync_q <= pin_meta_q;
    end
  end

  assign ev_edge = ev_sync_q & ~ev_last_q;

  // ============================================================
  // Power-up self-test and antenna check
  logic [PW-1:0] pwr_cnt_q, pwr_cnt_d;
  logic pwr_done_q, pwr_done_d, alarm_q, alarm_d, ext_q, ext_d;
  logic pwr_rise;

  always_comb begin
    pwr_cnt_d  = pwr_cnt_q;
    pwr_done_d = pwr_done_q;
    alarm_d    = alarm_q;
    ext_d      = ext_q;
    if (pwr_cnt_q == PW'(3)) ext_d = ~pin_sync_q[0];
    if (!pwr_done_q) begin
      if (pwr_cnt_q == PW'(SELFTEST_CYC - 1)) begin
        pwr_done_d = 1'b1;
        alarm_d    = ~pin_sync_q[1];
      end else begin
        pwr_cnt_d = pwr_cnt_q + PW'(1);
      end
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pwr_cnt_q  <= '0;
      pwr_done_q <= 1'b0;
      alarm_q    <= 1'b0;
      ext_q      <= 1'b0;
    end else if (ce_i) begin
      pwr_cnt_q  <= pwr_cnt_d;
      pwr_done_q <= pwr_done_d;
      alarm_q    <= alarm_d;
      ext_q      <= ext_d;
    end
  end

  assign pwr_rise     = pwr_done_d & ~pwr_done_q;
  assign power_led_o  = pwr_done_q;
  assign alarm_o      = alarm_q;
  // only a fresh reset ends the search
  assign ext_search_o = ext_q;

  // ============================================================
  // Register file and capture records
  ttps_pkg::ttps_rec_t rec_q [`TTPS_NUM_CH];
  ttps_pkg::ttps_rec_t rec_d [`TTPS_NUM_CH];
  logic [2:0]  rec_valid_q, rec_valid_d;
  logic        fmt_txt_q, fmt_txt_d, cont_q, cont_d;
  logic [1:0]  chsel_q, chsel_d;
  logic [5:0]  txt_idx_q, txt_idx_d;
  logic [15:0] period_q, period_d;
  logic [31:0] sdate_q, sdate_d, rdata_q, rdata_d;
  logic [23:0] stime_q, stime_d;
  logic [4:0]  irq_st_q, irq_st_d, irq_en_q, irq_en_d, irq_set;
  logic        wr_cmd, do_clear, do_preset, sel_valid, pulse_start;
  logic [1:0]  sel_ch;
  ttps_fmt_if  fmt_b ();

  function automatic logic wr_at(input logic [7:0] ofs);
    return reg_we_i && reg_addr_i == ofs;
  endfunction

  assign wr_cmd    = wr_at(`TTPS_OFS_CMD);
  assign do_clear  = wr_cmd && reg_wdata_i[`TTPS_CMD_CLEAR];
  assign do_preset = wr_cmd && reg_wdata_i[`TTPS_CMD_PRESET];
  // channel index 1..3 picks the record
  assign sel_ch    = 2'(chsel_q - 2'h1);
  assign sel_valid = chsel_q != 2'h0 && rec_valid_q[sel_ch];
  assign fmt_b.digits = rec_q[sel_ch];
  assign fmt_b.idx    = txt_idx_q;
  assign irq_set   = {pwr_rise, pulse_start, ev_edge};

  ttps_fmt u_fmt (
    .fmt_b (fmt_b)
  );

  always_comb begin
    rec_d       = rec_q;
    rec_valid_d = rec_valid_q;
    fmt_txt_d   = fmt_txt_q;
    cont_d      = cont_q;
    chsel_d     = chsel_q;
    txt_idx_d   = txt_idx_q;
    period_d    = period_q;
    sdate_d     = sdate_q;
    stime_d     = stime_q;
    irq_en_d    = irq_en_q;
    irq_st_d    = irq_st_q;
    rdata_d     = 32'h0000_0000;
    if (wr_at(`TTPS_OFS_FORMAT)) fmt_txt_d = reg_wdata_i[0];
    if (wr_at(`TTPS_OFS_CHSEL)) begin
      chsel_d   = reg_wdata_i[1:0];
      txt_idx_d = 6'h00;
    end
    if (wr_at(`TTPS_OFS_PERIOD)) period_d = reg_wdata_i[15:0];
    if (wr_at(`TTPS_OFS_CONT)) cont_d = reg_wdata_i[0];
    if (wr_at(`TTPS_OFS_SDATE)) sdate_d = reg_wdata_i;
    if (wr_at(`TTPS_OFS_STIME)) stime_d = reg_wdata_i[23:0];
    if (wr_at(`TTPS_OFS_IRQ_EN)) irq_en_d = reg_wdata_i[4:0];
    if (do_preset) begin
      fmt_txt_d = 1'b0;
      cont_d    = 1'b0;
      chsel_d   = `TTPS_DEF_CHSEL;
      period_d  = `TTPS_DEF_PERIOD;
      sdate_d   = `TTPS_DEF_SDATE;
      stime_d   = `TTPS_DEF_STIME;
      irq_en_d  = 5'h00;
      txt_idx_d = 6'h00;
    end
    // clear empties records, new edge wins
    if (do_clear) begin
      rec_valid_d = 3'h0;
      txt_idx_d   = 6'h00;
    end
    for (int c = 0; c < `TTPS_NUM_CH; c++) begin
      if (ev_edge[c]) begin
        rec_d[c]       = tod_bcd_i;
        rec_valid_d[c] = 1'b1;
      end
    end
    irq_st_d = irq_st_q;
    if (wr_at(`TTPS_OFS_IRQ_CLR)) irq_st_d = irq_st_q & ~reg_wdata_i[4:0];
    irq_st_d = irq_st_d | irq_set;
    if (reg_re_i) begin
      case (reg_addr_i)
        `TTPS_OFS_FORMAT:  rdata_d = {31'h0, fmt_txt_q};
        `TTPS_OFS_CHSEL:   rdata_d = {30'h0, chsel_q};
        `TTPS_OFS_TEXT: begin
          if (fmt_txt_q && sel_valid && txt_idx_q < `TTPS_TXT_LEN) begin
            rdata_d   = {24'h0, fmt_b.chr};
            txt_idx_d = txt_idx_q + 6'h01;
          end
        end
        `TTPS_OFS_REC0:    rdata_d = sel_valid ? rec_q[sel_ch][31:0] : '0;
        `TTPS_OFS_REC1:    rdata_d = sel_valid ? rec_q[sel_ch][63:32] : '0;
        `TTPS_OFS_REC2:    rdata_d = sel_valid ? rec_q[sel_ch][95:64] : '0;
        `TTPS_OFS_REC3: begin
          rdata_d = {sel_valid, 11'h0, rec_q[sel_ch][115:96]};
          if (!sel_valid) rdata_d = 32'h0000_0000;
        end
        `TTPS_OFS_PERIOD:  rdata_d = {16'h0, period_q};
        `TTPS_OFS_CONT:    rdata_d = {31'h0, cont_q};
        `TTPS_OFS_SDATE:   rdata_d = sdate_q;
        `TTPS_OFS_STIME:   rdata_d = {8'h0, stime_q};
        `TTPS_OFS_STATUS:  rdata_d = {28'h0, pulse_o, ext_q, alarm_q,
                                      pwr_done_q};
        `TTPS_OFS_IRQ_ST:  rdata_d = {27'h0, irq_st_q};
        `TTPS_OFS_IRQ_EN:  rdata_d = {27'h0, irq_en_q};
        // host link divisor for 9600 baud
        `TTPS_OFS_SERCFG:  rdata_d = BAUD_DIV;
        default:           rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int c = 0; c < `TTPS_NUM_CH; c++) rec_q[c] <= '0;
      rec_valid_q <= 3'h0;
      fmt_txt_q   <= 1'b0;
      cont_q      <= 1'b0;
      chsel_q     <= `TTPS_DEF_CHSEL;
      txt_idx_q   <= 6'h00;
      period_q    <= `TTPS_DEF_PERIOD;
      sdate_q     <= `TTPS_DEF_SDATE;
      stime_q     <= `TTPS_DEF_STIME;
      irq_en_q    <= 5'h00;
      irq_st_q    <= 5'h00;
      rdata_q     <= 32'h0000_0000;
    end else if (ce_i) begin
      rec_q       <= rec_d;
      rec_valid_q <= rec_valid_d;
      fmt_txt_q   <= fmt_txt_d;
      cont_q      <= cont_d;
      chsel_q     <= chsel_d;
      txt_idx_q   <= txt_idx_d;
      period_q    <= period_d;
      sdate_q     <= sdate_d;
      stime_q     <= stime_d;
      irq_en_q    <= irq_en_d;
      irq_st_q    <= irq_st_d;
      rdata_q     <= rdata_d;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign irq_o       = |(irq_st_q & irq_en_q);

  // ============================================================
  // Pulse scheduler
  // Pulses align to the second tick, so a past start fires on the
  // next tick rather than mid-second.
  ttps_pkg::ttps_pst_t st_q, st_d;
  logic [15:0] sec_cnt_q, sec_cnt_d, per_eff;
  logic [WW-1:0] wid_q, wid_d;
  logic start_ok;

  // BCD compare of now against start
  assign start_ok = tod_bcd_i[115:60] >= {sdate_q, stime_q};
  assign per_eff  = (period_q == 16'h0) ? 16'h0001 : period_q;
  assign pulse_start = st_d == ttps_pkg::PS_PULSE &&
                       st_q != ttps_pkg::PS_PULSE;

  always_comb begin
    st_d      = st_q;
    sec_cnt_d = sec_cnt_q;
    wid_d     = wid_q;
    case (st_q)
      ttps_pkg::PS_IDLE: begin
        if (cont_q) st_d = ttps_pkg::PS_WAIT;
      end
      ttps_pkg::PS_WAIT: begin
        if (!cont_q) begin
          st_d = ttps_pkg::PS_IDLE;
        end else if (pps_tick_i && start_ok) begin
          st_d      = ttps_pkg::PS_PULSE;
          sec_cnt_d = 16'h0001;
          wid_d     = '0;
        end
      end
      ttps_pkg::PS_RUN: begin
        if (!cont_q) begin
          st_d = ttps_pkg::PS_IDLE;
        end else if (pps_tick_i) begin
          if (sec_cnt_q >= per_eff) begin
            st_d      = ttps_pkg::PS_PULSE;
            sec_cnt_d = 16'h0001;
            wid_d     = '0;
          end else begin
            sec_cnt_d = sec_cnt_q + 16'h0001;
          end
        end
      end
      ttps_pkg::PS_PULSE: begin
        if (pps_tick_i) sec_cnt_d = sec_cnt_q + 16'h0001;
        if (wid_q == WW'(PULSE_CYC - 1)) begin
          st_d = cont_q ? ttps_pkg::PS_RUN : ttps_pkg::PS_IDLE;
        end else begin
          wid_d = wid_q + WW'(1);
        end
      end
      default: st_d = ttps_pkg::PS_IDLE;
    endcase
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_q      <= ttps_pkg::PS_IDLE;
      sec_cnt_q <= 16'h0000;
      wid_q     <= '0;
    end else if (ce_i) begin
      st_q      <= st_d;
      sec_cnt_q <= sec_cnt_d;
      wid_q     <= wid_d;
    end
  end

  assign pulse_o = st_q == ttps_pkg::PS_PULSE;

  // ============================================================
  // Assertions
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);

  a_clear_empties: assert property (
    ce_i && do_clear && ev_edge == 3'h0 |=> rec_valid_q == 3'h0)
    else $error("records survive a clear");
  a_text_comma: assert property (
    ce_i && reg_re_i && reg_addr_i == `TTPS_OFS_TEXT && fmt_txt_q &&
    sel_valid && txt_idx_q == 6'h04 |=> reg_rdata_o == 32'h0000_002C)
    else $error("text record lacks comma after year");
  a_capture_ch: assert property (
    ce_i && ev_edge[1] |=> rec_valid_q[1] && rec_q[1] == $past(tod_bcd_i))
    else $error("edge not captured");
  a_query_ch: assert property (
    ce_i && reg_re_i && reg_addr_i == `TTPS_OFS_REC3 && chsel_q == 2'h2
    |=> reg_rdata_o[31] == $past(rec_valid_q[1]))
    else $error("wrong channel answered");
  a_pulse_width: assert property (
    $fell(pulse_o) |-> $past(wid_q) == WW'(PULSE_CYC - 1))
    else $error("pulse width wrong");
  a_past_start: assert property (
    ce_i && st_q == ttps_pkg::PS_WAIT && cont_q && pps_tick_i && start_ok
    |=> pulse_o)
    else $error("past start did not pulse");
  a_future_idle: assert property (
    $rose(pulse_o) && $past(st_q) == ttps_pkg::PS_WAIT |->
    $past(start_ok) && $past(pps_tick_i))
    else $error("pulse before start");
  a_stop_off: assert property (
    ce_i && !cont_q && st_q == ttps_pkg::PS_RUN |=> st_q == ttps_pkg::PS_IDLE)
    else $error("train kept running");
  a_preset_def: assert property (
    ce_i && do_preset |=> period_q == `TTPS_DEF_PERIOD && !cont_q)
    else $error("preset left parameters");
  a_power_time: assert property (
    $rose(power_led_o) |-> $past(pwr_cnt_q) == PW'(SELFTEST_CYC - 1))
    else $error("power indicator at wrong time");
  a_search_hold: assert property (
    pwr_cnt_q > PW'(4) |-> $stable(ext_search_o))
    else $error("search flag changed after power-up");

  c_capture: cover property (ce_i && ev_edge[2]);
  c_text_read: cover property (
    ce_i && reg_re_i && reg_addr_i == `TTPS_OFS_TEXT && fmt_txt_q);
  c_train: cover property ($rose(pulse_o) ##[1:1000] $rose(pulse_o));
  c_stop: cover property ($fell(cont_q) ##[1:900] $fell(pulse_o));
endmodule

//--- test/ttps_tod_src.sv
// Time source model: BCD time of day and a once-per-second tick.
module ttps_tod_src #(
  parameter int unsigned GAP = 40
) (
  // Clock and reset
  input  wire logic         clock_i,
  input  wire logic         resetn_i,
  // Time out
  output logic      [115:0] tod_o,
  output logic              pps_o
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] LAST = 16'(GAP - 1);
  logic [7:0]  sec_q;
  logic [15:0] cnt_q;
  // ============================================================
  // Tick and seconds
  // Seconds change in the tick's own cycle, so a compare sees new time.
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_q <= 16'h0000;
      pps_o <= 1'b0;
      sec_q <= 8'h00;
    end else begin
      pps_o <= (cnt_q == LAST);
      cnt_q <= (cnt_q == LAST) ? 16'h0000 : cnt_q + 16'h0001;
      if (cnt_q == LAST) begin
        sec_q <= (sec_q[3:0] == 4'h9) ? {sec_q[7:4] + 4'h1, 4'h0}
                                      : sec_q + 8'h01;
      end
    end
  end
  assign tod_o = {16'h2024, 8'h07, 8'h25, 8'h13, 8'h01, sec_q,
                  24'h12_3456, 36'h0_1234_5678};
endmodule

//--- test/test_time_tag_pulse_scheduler.sv
// Self-checking bench for the time tag and pulse scheduler.
`include "ttps_regs.svh"
module test_time_tag_pulse_scheduler;
  timeunit 1ns;
  timeprecision 1ps;
  // ============================================================
  // Signals
  logic                clock_i = 1'b0;
  logic                resetn_i = 1'b0;
  logic [7:0]          reg_addr_i = 8'h00;
  logic [31:0]         reg_wdata_i = 32'h0000_0000;
  logic                reg_we_i = 1'b0;
  logic                reg_re_i = 1'b0;
  logic                ce_i = 1'b1;
  logic [31:0]         reg_rdata_o;
  ttps_pkg::ttps_rec_t tod;
  ttps_pkg::ttps_rec_t snap [3];
  logic                pps;
  logic [2:0]          event_i = 3'h0;
  logic                antenna_ok_i = 1'b0;
  logic                selftest_ok_i = 1'b0;
  logic                pulse_o, power_led_o, alarm_o, ext_search_o, irq_o;
  logic [31:0]         rd;
  int                  num_errors = 0;
  int                  tests_run = 0;
  int                  cycles = 0;
  int                  pcnt = 0;
  int                  phigh = 0;
  int                  pwid = 0;
  always #12.5 clock_i = ~clock_i;
  // ============================================================
  // Design and time source
  ttps_top #(.SELFTEST_CYC(16), .PULSE_CYC(4)) uut (
    .clock_i(clock_i), .resetn_i(resetn_i), .ce_i(ce_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o),
    .tod_bcd_i(tod), .pps_tick_i(pps), .event_i(event_i),
    .antenna_ok_i(antenna_ok_i), .selftest_ok_i(selftest_ok_i),
    .pulse_o(pulse_o), .power_led_o(power_led_o), .alarm_o(alarm_o),
    .ext_search_o(ext_search_o), .irq_o(irq_o));
  ttps_tod_src #(.GAP(40)) src (
    .clock_i(clock_i), .resetn_i(resetn_i), .tod_o(tod), .pps_o(pps));
  // ============================================================
  // Watchdog and pulse monitor
  // Width and count are measured here so scenarios need not poll each edge.
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles > 20000) begin
      num_errors++;
      results();
    end
  end
  always @(posedge clock_i) begin
    if (pulse_o === 1'b1) begin
      phigh <= phigh + 1;
    end else if (phigh != 0) begin
      pwid <= phigh;
      phigh <= 0;
    end
    if (pulse_o === 1'b1 && phigh == 0) begin
      pcnt <= pcnt + 1;
    end
  end
  // ============================================================
  // Shared tasks
  task automatic results();
    if (num_errors == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got,
                     input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      do step(1); while (pps !== 1'b1);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    reg_we_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clock_i);
    reg_we_i <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge clock_i);
    reg_re_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clock_i);
    reg_re_i <= 1'b0;
    #1 rd = reg_rdata_o;
  endtask
  task automatic do_reset(input logic ant, input logic st);
    @(posedge clock_i);
    resetn_i <= 1'b0;
    antenna_ok_i <= ant;
    selftest_ok_i <= st;
    step(4);
    chk("outs_in_reset", 32'({pulse_o, power_led_o, alarm_o, irq_o}), 0);
    @(posedge clock_i);
    resetn_i <= 1'b1;
  endtask
  // ============================================================
  // Scenarios
  task automatic t_search();
    do_reset(1'b0, 1'b0);
    step(24);
    chk("ext_search", 32'(ext_search_o), 1);
    rdr(`TTPS_OFS_STATUS);
    chk("status_fail", rd, 32'h0000_0007);
  endtask
  task automatic t_power();
    // power cycled to end the search
    do_reset(1'b1, 1'b1);
    step(14);
    chk("power_early", 32'({power_led_o, alarm_o, ext_search_o}), 0);
    step(4);
    chk("power_late", 32'({power_led_o, alarm_o, ext_search_o}), 4);
    rdr(`TTPS_OFS_SERCFG);
    chk("sercfg", rd, 32'h0000_1046);
    rdr(8'h44);
    chk("unmapped", rd, 32'h0000_0000);
  endtask
  task automatic t_future();
    int n;
    wr(`TTPS_OFS_PERIOD, 32'h0000_0001);
    wr(`TTPS_OFS_SDATE, 32'h2024_0725);
    wr(`TTPS_OFS_STIME, 32'h0013_0120);
    wr(`TTPS_OFS_CONT, 32'h0000_0001);
    do step(1); while (tod[67:60] !== 8'h20);
    chk("idle_before", 32'(pcnt), 0);
    step(3);
    chk("first_pulse", 32'(pcnt), 1);
    ticks(3);
    step(3);
    chk("per_second", 32'(pcnt), 4);
    chk("pulse_width", 32'(pwid), 4);
    // Switch off one cycle into a fresh pulse so it must still complete.
    ticks(1);
    wr(`TTPS_OFS_CONT, 32'h0000_0000);
    step(6);
    chk("stop_width", 32'(pwid), 4);
    n = pcnt;
    ticks(3);
    chk("stopped", 32'(pcnt), 32'(n));
  endtask
  task automatic t_past();
    int n;
    wr(`TTPS_OFS_PERIOD, 32'h0000_0002);
    wr(`TTPS_OFS_SDATE, 32'h2023_0101);
    wr(`TTPS_OFS_STIME, 32'h0000_0000);
    ticks(1);
    n = pcnt;
    wr(`TTPS_OFS_CONT, 32'h0000_0001);
    ticks(1);
    step(3);
    chk("past_start", 32'(pcnt), 32'(n + 1));
    ticks(4);
    step(3);
    chk("period_two", 32'(pcnt), 32'(n + 3));
    wr(`TTPS_OFS_CONT, 32'h0000_0000);
  endtask
  task automatic t_capture();
    wr(`TTPS_OFS_IRQ_EN, 32'h0000_0001);
    for (int c = 0; c < 3; c++) begin
      ticks(1);
      snap[c] = tod;
      event_i[c] <= 1'b1;
      step(6);
      event_i[c] <= 1'b0;
      wr(`TTPS_OFS_CHSEL, 32'(c + 1));
      rdr(`TTPS_OFS_REC0);
      chk("rec0", rd, snap[c][31:0]);
      rdr(`TTPS_OFS_REC1);
      chk("rec1", rd, snap[c][63:32]);
      rdr(`TTPS_OFS_REC2);
      chk("rec2", rd, snap[c][95:64]);
      rdr(`TTPS_OFS_REC3);
      chk("rec3", rd, {1'b1, 11'h000, snap[c][115:96]});
    end
    chk("irq_on", 32'(irq_o), 1);
    wr(`TTPS_OFS_IRQ_EN, 32'h0000_0000);
    rdr(`TTPS_OFS_IRQ_ST);
    chk("irq_masked", 32'(irq_o), 0);
    // Pulse start and power-up bits are still set from earlier scenarios.
    chk("irq_status", rd, 32'h0000_001F);
    wr(`TTPS_OFS_IRQ_CLR, 32'h0000_0007);
    rdr(`TTPS_OFS_IRQ_ST);
    chk("irq_cleared", rd, 32'h0000_0018);
  endtask
  task automatic t_text();
    int n;
    logic [7:0] e;
    n = 0;
    wr(`TTPS_OFS_FORMAT, 32'h0000_0001);
    wr(`TTPS_OFS_CHSEL, 32'h0000_0002);
    for (int i = 0; i < 35; i++) begin
      if (i == 4 || i == 7 || i == 10 || i == 13 || i == 16 || i == 25) begin
        e = 8'h2C;
      end else begin
        e = 8'h30 + 8'(snap[1][115 - 4 * n -: 4]);
        n++;
      end
      rdr(`TTPS_OFS_TEXT);
      chk("text_char", rd, 32'(e));
    end
    rdr(`TTPS_OFS_TEXT);
    chk("text_end", rd, 32'h0000_0000);
  endtask
  task automatic t_clear();
    wr(`TTPS_OFS_CMD, 32'h0000_0001);
    for (int c = 1; c < 4; c++) begin
      wr(`TTPS_OFS_CHSEL, 32'(c));
      rdr(`TTPS_OFS_REC3);
      chk("clr_rec3", rd, 32'h0000_0000);
      rdr(`TTPS_OFS_REC0);
      chk("clr_rec0", rd, 32'h0000_0000);
    end
  endtask
  task automatic t_preset();
    wr(`TTPS_OFS_CHSEL, 32'h0000_0003);
    wr(`TTPS_OFS_PERIOD, 32'h0000_0005);
    wr(`TTPS_OFS_IRQ_EN, 32'h0000_001F);
    wr(`TTPS_OFS_CMD, 32'h0000_0002);
    rdr(`TTPS_OFS_PERIOD);
    chk("def_period", rd, 32'h0000_0001);
    rdr(`TTPS_OFS_FORMAT);
    chk("def_format", rd, 32'h0000_0000);
    rdr(`TTPS_OFS_CHSEL);
    chk("def_chsel", rd, 32'h0000_0001);
    rdr(`TTPS_OFS_IRQ_EN);
    chk("def_irq_en", rd, 32'h0000_0000);
  endtask
  task automatic t_freeze();
    @(posedge clock_i);
    ce_i <= 1'b0;
    wr(`TTPS_OFS_PERIOD, 32'h0000_0009);
    ce_i <= 1'b1;
    rdr(`TTPS_OFS_PERIOD);
    chk("frozen_write", rd, 32'h0000_0001);
  endtask
  // ============================================================
  // Main sequence
  // The future start runs before the past start, while the seconds are still below it.
  initial begin
    t_search();
    t_power();
    t_future();
    t_past();
    t_capture();
    t_text();
    t_clear();
    t_preset();
    t_freeze();
    results();
  end
endmodule
